/* design/gtc_defines.svh */
// Operation
// - The reload register is 32 bits wide, writable, and supplies the counter's load value.
// - Any write to the 8-bit clear register reloads the counter from the reload register.
// - The live count is readable, and writes to its address do not touch the counter.
// - The capture register holds the count latched when the enabled selected event occurs.
// - Control bit 17 enables event capture; when it is clear nothing is captured.
// - Control bits 16 to 12 pick one of 32 event sources for capture.
// - Control bits 11 to 9 pick the source: 000 oscillator, 001 core clock, 010 or 011 secondary clock.
// - Control bit 8 set counts up and clear counts down, down being the reset state.
// - Control bit 7 enables counting and is clear after reset.
// - Control bit 6 set gives periodic mode with reload at rollover, clear gives free running.
// - Bits 5 to 4 pick binary 00, time of day to 23 hours 10, or to 255 hours 11.
// - Bits 3 to 0 divide the source by 1, 16, 256 or 32768 for codes 0000, 0100, 1000, 1111.
// - The counter reloads on overflow in periodic mode only, and in every mode at once on a write to the clear register.
// - A capture copies the count without disturbing the running counter.
// - A write to the clear register also clears the pending interrupt flag, unless a rollover occurs in the same cycle.
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH
`define GTC_ADDR_RELOAD 32'hFFFF0380
`define GTC_ADDR_COUNT 32'hFFFF0384
`define GTC_ADDR_CTL 32'hFFFF0388
`define GTC_ADDR_CLR 32'hFFFF038C
`define GTC_ADDR_CAP 32'hFFFF0390
`define GTC_RST_RELOAD 32'h00000000
`define GTC_RST_COUNT 32'h00000000
`define GTC_RST_CTL 32'h00000000
`define GTC_RST_CAP 32'h00000000
`define GTC_CTL_MASK 32'h0003FFFF
`define GTC_CAP_EN_BIT 17
`define GTC_EVSEL_HI 16
`define GTC_EVSEL_LO 12
`define GTC_SRC_HI 11
`define GTC_SRC_LO 9
`define GTC_UP_BIT 8
`define GTC_EN_BIT 7
`define GTC_PER_BIT 6
`define GTC_FMT_HI 5
`define GTC_FMT_LO 4
`define GTC_PRE_HI 3
`define GTC_PRE_LO 0
`define GTC_PRE_DIV1 4'h0
`define GTC_PRE_DIV16 4'h4
`define GTC_PRE_DIV256 4'h8
`define GTC_PRE_DIV32K 4'hF
`define GTC_LAST_DIV1 15'h0000
`define GTC_LAST_DIV16 15'h000F
`define GTC_LAST_DIV256 15'h00FF
`define GTC_LAST_DIV32K 15'h7FFF
`define GTC_HUND_MAX 8'h63
`define GTC_SEC_MAX 8'h3B
`define GTC_HRS_MAX23 8'h17
`define GTC_HRS_MAX255 8'hFF
`endif

/* design/gtc_pkg.sv */
package gtc_pkg;
    typedef enum logic [1:0] {
        GTC_FMT_BIN,
        GTC_FMT_RSV,
        GTC_FMT_H23,
        GTC_FMT_H255
    } gtc_fmt_t;
    typedef enum logic [2:0] {
        GTC_SRC_OSC,
        GTC_SRC_CORE,
        GTC_SRC_SEC_A,
        GTC_SRC_SEC_B,
        GTC_SRC_NONE_4,
        GTC_SRC_NONE_5,
        GTC_SRC_NONE_6,
        GTC_SRC_NONE_7
    } gtc_src_t;
endpackage

/* design/gtc_timer.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "gtc_defines.svh"
module gtc_timer
    import gtc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_osc_clk,
    input wire logic i_secondary_clock,
    input wire logic [31:0] i_events,
    output logic [31:0] o_rdata,
    output logic o_irq
);

    logic [31:0] reload_value_r;
    logic [31:0] current_count_r;
    logic [31:0] captured_count_r;
    logic [31:0] timer_control_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic osc_d_r;
    logic sec_d_r;
    logic [31:0] ev_d_r;
    logic [14:0] pre_cnt_r;
    logic [31:0] current_count_nxt;
    logic [32:0] step_w;
    logic src_tick;
    logic tick;
    logic wrap;
    logic clr_wr;
    logic cap_fire;
    logic [31:0] ev_rise;
    logic [4:0] ev_sel;
    logic cnt_en;
    logic cnt_up;
    logic periodic;
    gtc_fmt_t fmt;
    gtc_src_t src;

    // Last prescaler count before a tick; reserved codes act as divide by 1
    function automatic logic [14:0] div_last(input logic [3:0] code);
        logic [14:0] r;
        case (code)
            `GTC_PRE_DIV16: r = `GTC_LAST_DIV16;
            `GTC_PRE_DIV256: r = `GTC_LAST_DIV256;
            `GTC_PRE_DIV32K: r = `GTC_LAST_DIV32K;
            default: r = `GTC_LAST_DIV1;
        endcase
        return r;
    endfunction

    // One step of the hours:minutes:seconds:hundredths count, carry out on top
    function automatic logic [32:0] hms_step(input logic [31:0] v, input logic up,
                                             input logic [7:0] hmax);
        logic [31:0] r;
        logic c;
        logic [7:0] lim;
        logic [7:0] fld;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 4; i++) begin
            lim = (i == 3) ? hmax : ((i == 0) ? `GTC_HUND_MAX : `GTC_SEC_MAX);
            fld = v[i*8 +: 8];
            if (c) begin
                if (up) begin
                    if (fld >= lim) begin
                        fld = 8'h00;
                    end else begin
                        fld = fld + 8'h01;
                        c = 1'b0;
                    end
                end else begin
                    if (fld == 8'h00) begin
                        fld = lim;
                    end else begin
                        fld = fld - 8'h01;
                        c = 1'b0;
                    end
                end
            end
            r[i*8 +: 8] = fld;
        end
        return {c, r};
    endfunction

    assign cnt_en = timer_control_r[`GTC_EN_BIT];
    assign cnt_up = timer_control_r[`GTC_UP_BIT];
    assign periodic = timer_control_r[`GTC_PER_BIT];
    assign fmt = gtc_fmt_t'(timer_control_r[`GTC_FMT_HI:`GTC_FMT_LO]);
    assign src = gtc_src_t'(timer_control_r[`GTC_SRC_HI:`GTC_SRC_LO]);
    assign ev_sel = timer_control_r[`GTC_EVSEL_HI:`GTC_EVSEL_LO];
    assign clr_wr = i_wr && (i_addr == `GTC_ADDR_CLR);
    assign ev_rise = i_events & ~ev_d_r;
    assign cap_fire = timer_control_r[`GTC_CAP_EN_BIT] && ev_rise[ev_sel];

    // Source selection; codes 1xx select nothing
    always_comb begin
        case (src)
            GTC_SRC_OSC: src_tick = i_osc_clk && !osc_d_r;
            GTC_SRC_CORE: src_tick = 1'b1;
            GTC_SRC_SEC_A, GTC_SRC_SEC_B: src_tick = i_secondary_clock && !sec_d_r;
            default: src_tick = 1'b0;
        endcase
    end

    // At or past the last count, so a smaller divide written mid-count still ticks
    assign tick = cnt_en && src_tick &&
                  (pre_cnt_r >= div_last(timer_control_r[`GTC_PRE_HI:`GTC_PRE_LO]));

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            osc_d_r <= 1'b0;
            sec_d_r <= 1'b0;
            ev_d_r <= 32'h00000000;
        end else begin
            osc_d_r <= i_osc_clk;
            sec_d_r <= i_secondary_clock;
            ev_d_r <= i_events;
        end
    end

    // Prescaler runs only while counting is enabled
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_cnt_r <= 15'h0000;
        end else if (!cnt_en || tick) begin
            pre_cnt_r <= 15'h0000;
        end else if (src_tick) begin
            pre_cnt_r <= pre_cnt_r + 15'h0001;
        end
    end

    always_comb begin
        case (fmt)
            GTC_FMT_H23: step_w = hms_step(current_count_r, cnt_up, `GTC_HRS_MAX23);
            GTC_FMT_H255: step_w = hms_step(current_count_r, cnt_up, `GTC_HRS_MAX255);
            default: begin
                if (cnt_up) begin
                    step_w = {1'b0, current_count_r} + 33'h000000001;
                end else begin
                    step_w = {current_count_r == 32'h00000000, current_count_r - 32'h00000001};
                end
            end
        endcase
    end

    assign wrap = tick && step_w[32];

    always_comb begin
        current_count_nxt = current_count_r;
        if (clr_wr) begin
            current_count_nxt = reload_value_r;
        end else if (tick) begin
            if (wrap && periodic) begin
                current_count_nxt = reload_value_r;
            end else begin
                current_count_nxt = step_w[31:0];
            end
        end
    end

    // Writes to the count address are ignored
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            current_count_r <= `GTC_RST_COUNT;
        end else begin
            current_count_r <= current_count_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            reload_value_r <= `GTC_RST_RELOAD;
        end else if (i_wr && (i_addr == `GTC_ADDR_RELOAD)) begin
            reload_value_r <= i_wdata;
        end
    end

    // Reserved control bits are not stored and read as zero
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            timer_control_r <= `GTC_RST_CTL;
        end else if (i_wr && (i_addr == `GTC_ADDR_CTL)) begin
            timer_control_r <= i_wdata & `GTC_CTL_MASK;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            captured_count_r <= `GTC_RST_CAP;
        end else if (cap_fire) begin
            captured_count_r <= current_count_r;
        end
    end

    // A rollover in the same cycle as a clear keeps the flag set
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_r <= 1'b0;
        end else if (wrap) begin
            irq_r <= 1'b1;
        end else if (clr_wr) begin
            irq_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `GTC_ADDR_RELOAD: rdata_r <= reload_value_r;
                `GTC_ADDR_COUNT: rdata_r <= current_count_r;
                `GTC_ADDR_CTL: rdata_r <= timer_control_r;
                `GTC_ADDR_CAP: rdata_r <= captured_count_r;
                default: rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    AST_RELOAD_WR: assert property (
        i_wr && i_addr == `GTC_ADDR_RELOAD |=> reload_value_r == $past(i_wdata))
        else $error("reload register did not take written value");
    AST_CLR_RELOAD: assert property (
        clr_wr |=> current_count_r == $past(reload_value_r) && o_irq == $past(wrap))
        else $error("clear write did not reload counter");
    AST_COUNT_RO: assert property (
        i_wr && i_addr == `GTC_ADDR_COUNT && !tick |=> $stable(current_count_r))
        else $error("write to count address changed counter");
    AST_CAPTURE: assert property (
        cap_fire |=> captured_count_r == $past(current_count_r))
        else $error("capture did not latch count");
    AST_NO_CAPTURE: assert property (
        !timer_control_r[`GTC_CAP_EN_BIT] |=> $stable(captured_count_r))
        else $error("capture happened while disabled");
    AST_EVSEL: assert property (
        $changed(captured_count_r) |-> $past(ev_rise[ev_sel]))
        else $error("capture without selected event edge");
    AST_CORE_SRC: assert property (
        cnt_en && src == GTC_SRC_CORE && timer_control_r[3:0] == `GTC_PRE_DIV1 |-> tick)
        else $error("core clock source did not tick every cycle");
    AST_BIN_STEP: assert property (
        tick && fmt == GTC_FMT_BIN && !wrap && !clr_wr |=>
        current_count_r == ($past(cnt_up) ? $past(current_count_r) + 32'h00000001
                                          : $past(current_count_r) - 32'h00000001))
        else $error("binary count step wrong");
    AST_HALT: assert property (
        !cnt_en && !clr_wr |=> $stable(current_count_r))
        else $error("counter moved while disabled");
    AST_PERIODIC: assert property (
        wrap && periodic && !clr_wr |=> current_count_r == $past(reload_value_r))
        else $error("periodic rollover did not reload");
    AST_HMS_RANGE: assert property (
        tick && fmt[1] && !clr_wr && current_count_r[7:0] <= `GTC_HUND_MAX |=>
        current_count_r[7:0] <= `GTC_HUND_MAX)
        else $error("hundredths left range");
    AST_DIV16: assert property (
        tick && timer_control_r[3:0] == `GTC_PRE_DIV16 && src == GTC_SRC_CORE |->
        $past(pre_cnt_r) == 15'h000E)
        else $error("divide by 16 spacing wrong");
    AST_CAP_NO_DISTURB: assert property (
        cap_fire && !tick && !clr_wr |=> $stable(current_count_r))
        else $error("capture disturbed counter");
    AST_IRQ_SET: assert property (
        wrap |=> o_irq ##1 (o_irq || $past(clr_wr)))
        else $error("rollover did not hold interrupt");
    AST_IRQ_HOLD: assert property (
        o_irq && !clr_wr |=> o_irq)
        else $error("interrupt flag dropped without clear");
    AST_IRQ_CLR: assert property (
        clr_wr && !wrap |=> !o_irq)
        else $error("clear write did not clear interrupt flag");
    AST_FREE_WRAP: assert property (
        wrap && !periodic && !clr_wr && fmt == GTC_FMT_BIN |=>
        current_count_r == ($past(cnt_up) ? 32'h00000000 : 32'hFFFFFFFF))
        else $error("free running rollover value wrong");
    AST_PRE_HALT: assert property (
        !cnt_en |=> pre_cnt_r == 15'h0000)
        else $error("prescaler moved while disabled");
    AST_RD_COUNT: assert property (
        i_rd && i_addr == `GTC_ADDR_COUNT |=> o_rdata == $past(current_count_r))
        else $error("count read returned wrong value");
    AST_RD_CAP: assert property (
        i_rd && i_addr == `GTC_ADDR_CAP |=> o_rdata == $past(captured_count_r))
        else $error("capture read returned wrong value");
    AST_HMS_HOURS: assert property (
        tick && fmt == GTC_FMT_H23 && !clr_wr && current_count_r[31:24] <= `GTC_HRS_MAX23 |=>
        current_count_r[31:24] <= `GTC_HRS_MAX23)
        else $error("hours left 23 hour range");

    COV_CAPTURE: cover property (cap_fire && cnt_en);
    COV_PERIODIC: cover property (wrap && periodic);
    COV_HMS_WRAP: cover property (wrap && fmt == GTC_FMT_H23);
    COV_CLEAR_IRQ: cover property (o_irq && clr_wr);
    COV_DIV16_TICK: cover property (tick && timer_control_r[3:0] == `GTC_PRE_DIV16);

endmodule

/* tb/gtc_tb.sv */
`timescale 1ns/10ps
`include "gtc_defines.svh"
module tb
    import gtc_pkg::*;
();
    localparam logic [31:0] EN = 32'h00000080;
    localparam logic [31:0] UNMAPPED = 32'hFFFF0394;
    localparam logic [31:0] LD [11] = '{32'h64, 32'h64, 32'h64, 32'h64, 32'hFFFFFFFA, 32'h5, 32'h0, 32'h0,
        32'h62, 32'h173B3B63, 32'h0};
    localparam logic [31:0] CT [11] = '{32'h25200, 32'h204, 32'h208, 32'h20F, 32'h3F300, 32'h240, 32'h220,
        32'h230, 32'h320, 32'h320, 32'h200};
    localparam int ED [11] = '{10, 40, 600, 33000, 10, 10, 2, 2, 2, 2, 2};
    localparam logic [31:0] EX [11] = '{32'h5A, 32'h62, 32'h62, 32'h63, 32'h4, 32'h1, 32'h173B3B62,
        32'hFF3B3B62, 32'h100, 32'h1, 32'hFFFFFFFE};
    localparam logic IR [11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    localparam gtc_src_t SRC [4] = '{GTC_SRC_OSC, GTC_SRC_SEC_A, GTC_SRC_SEC_B, GTC_SRC_NONE_4};
    localparam logic [31:0] SX [4] = '{32'h3, 32'h5, 32'h5, 32'h0};
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] i_events = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_osc_clk = 1'b0;
    logic i_secondary_clock = 1'b0;
    logic [31:0] o_rdata;
    logic o_irq;
    logic rd_d = 1'b0;
    logic rnd_ev = 1'b0;
    logic [31:0] exp_q [$];
    logic [31:0] r;
    logic [31:0] cap;
    logic [4:0] sel;
    int error_cnt = 0;
    int n_tests = 0;
    integer seed = 32'hC3A6;

    always #2 i_core_clk = ~i_core_clk;

    gtc_timer dut (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_osc_clk(i_osc_clk),
        .i_secondary_clock(i_secondary_clock),
        .i_events(i_events),
        .o_rdata(o_rdata),
        .o_irq(o_irq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // Expected read data is queued here and compared by the monitor below
    task rd(input logic [31:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask

    task pulse(input logic [31:0] v);
        @(posedge i_core_clk);
        i_events <= v;
        @(posedge i_core_clk);
        i_events <= 32'h0;
        repeat (2) @(posedge i_core_clk);
    endtask

    // At divide by 1, ticks counted equal the enabled edges, from the enabling write to the disabling one
    task run(input logic [31:0] ld, input logic [31:0] ct, input int edges, input logic [31:0] ex,
        input logic irq);
        wr(`GTC_ADDR_RELOAD, ld);
        wr(`GTC_ADDR_CLR, 32'h0);
        wr(`GTC_ADDR_CTL, ct | EN);
        rnd_ev <= 1'b1;
        repeat (edges - 2) @(posedge i_core_clk);
        rnd_ev <= 1'b0;
        wr(`GTC_ADDR_CTL, ct);
        rd(`GTC_ADDR_COUNT, ex);
        @(negedge i_core_clk);
        check({31'h0, o_irq}, {31'h0, irq});
    endtask

    always @(posedge i_core_clk) rd_d <= i_rd;

    always @(posedge i_core_clk) begin
        if (rnd_ev) begin
            i_events <= $random(seed);
        end
    end

    always @(negedge i_core_clk) begin
        if (rd_d === 1'b1) begin
            check(o_rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (5) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        rd(`GTC_ADDR_RELOAD, `GTC_RST_RELOAD);
        rd(`GTC_ADDR_COUNT, `GTC_RST_COUNT);
        rd(`GTC_ADDR_CTL, `GTC_RST_CTL);
        rd(`GTC_ADDR_CLR, 32'h0);
        rd(`GTC_ADDR_CAP, `GTC_RST_CAP);
        rd(UNMAPPED, 32'h0);
        @(negedge i_core_clk);
        check({31'h0, o_irq}, 32'h0);
        $display("test reset done");
        r = $random(seed);
        wr(`GTC_ADDR_RELOAD, r);
        rd(`GTC_ADDR_RELOAD, r);
        // Software keeps the reserved control bits at zero
        wr(`GTC_ADDR_CTL, 32'h0003FF7F);
        rd(`GTC_ADDR_CTL, 32'h0003FF7F);
        wr(`GTC_ADDR_CTL, 32'h0);
        wr(`GTC_ADDR_COUNT, ~r);
        rd(`GTC_ADDR_COUNT, 32'h0);
        wr(`GTC_ADDR_CAP, ~r);
        rd(`GTC_ADDR_CAP, 32'h0);
        wr(UNMAPPED, r);
        rd(UNMAPPED, 32'h0);
        wr(`GTC_ADDR_CLR, ~r);
        rd(`GTC_ADDR_COUNT, r);
        $display("test registers done");
        cap = 32'h0;
        for (int i = 0; i < 3; i++) begin
            sel = 5'($random(seed));
            r = $random(seed);
            wr(`GTC_ADDR_RELOAD, r);
            wr(`GTC_ADDR_CLR, 32'h0);
            wr(`GTC_ADDR_CTL, 32'h20000 | {15'h0, sel, 12'h0});
            pulse(~(32'h1 << sel));
            rd(`GTC_ADDR_CAP, cap);
            pulse(32'h1 << sel);
            rd(`GTC_ADDR_CAP, r);
            cap = r;
            wr(`GTC_ADDR_CTL, {15'h0, sel, 12'h0});
            wr(`GTC_ADDR_RELOAD, ~r);
            wr(`GTC_ADDR_CLR, 32'h0);
            pulse(32'h1 << sel);
            rd(`GTC_ADDR_CAP, cap);
        end
        $display("test capture done");
        for (int i = 0; i < 11; i++) begin
            run(LD[i], CT[i], ED[i], EX[i], IR[i]);
        end
        wr(`GTC_ADDR_CLR, 32'h0);
        @(negedge i_core_clk);
        check({31'h0, o_irq}, 32'h0);
        $display("test count done");
        for (int i = 0; i < 4; i++) begin
            wr(`GTC_ADDR_RELOAD, 32'h64);
            wr(`GTC_ADDR_CLR, 32'h0);
            wr(`GTC_ADDR_CTL, {20'h0, SRC[i], 9'h0} | EN);
            for (int p = 0; p < 5; p++) begin
                @(posedge i_core_clk);
                i_osc_clk <= (p < 3);
                i_secondary_clock <= 1'b1;
                repeat (3) @(posedge i_core_clk);
                i_osc_clk <= 1'b0;
                i_secondary_clock <= 1'b0;
                repeat (3) @(posedge i_core_clk);
            end
            wr(`GTC_ADDR_CTL, {20'h0, SRC[i], 9'h0});
            rd(`GTC_ADDR_COUNT, 32'h64 - SX[i]);
        end
        $display("test source done");
        repeat (4) @(posedge i_core_clk);
        conclude;
    end

    initial begin
        #400000;
        error_cnt++;
        conclude;
    end
endmodule
